// File: design/ssr_map.svh
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// Register byte offsets
`define SSR_OFS_CTRL       8'h00
`define SSR_OFS_STATUS     8'h04
`define SSR_OFS_RX_WORD    8'h08
`define SSR_OFS_REQ        8'h0c
`define SSR_OFS_RELAY      8'h10
`define SSR_OFS_FRAMES     8'h14

// Control fields
`define SSR_CTRL_HOLD      0
`define SSR_CTRL_RELAY_EN  1
`define SSR_CTRL_SRC_LO    2
`define SSR_CTRL_SRC_W     3
`define SSR_CTRL_RESET     32'h0000_001e

// Status fields
`define SSR_ST_LEVEL_LO    0
`define SSR_ST_PEND        2
`define SSR_ST_LOAD        3
`define SSR_ST_BITS_LO     8

// Function word layout
`define SSR_FRAME_BITS     32
`define SSR_MOTOR_LO       0
`define SSR_MOTOR_N        6
`define SSR_ROOM_LO        8
`define SSR_ROOM_N         7

`endif

// File: design/ssr_pkg.sv
package ssr_pkg;

  // Motor direction channels, bit 0 is head raise
  typedef struct packed {
    logic height_lower_relay;
    logic height_raise_relay;
    logic foot_lower_relay;
    logic foot_raise_relay;
    logic head_lower_relay;
    logic head_raise_relay;
  } ssr_motor_t;

  // Room channels, bit 0 is the television
  typedef struct packed {
    logic indirect_left_relay;
    logic indirect_right_relay;
    logic direct_left_relay;
    logic direct_right_relay;
    logic radio_right_relay;
    logic radio_left_relay;
    logic tv_relay;
  } ssr_room_t;

  // One captured function frame on its way to the decoder
  typedef struct packed {
    logic [31:0] word;
  } ssr_frame_t;

endpackage : ssr_pkg

// File: design/ssr_sync.sv
`timescale 1ns/1ps
module ssr_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Two stages; only the second stage is read outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ssr_sync

// File: design/ssr_buf2.sv
`timescale 1ns/1ps
module ssr_buf2
  import ssr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire ssr_frame_t in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output ssr_frame_t      out_data,
  output logic [1:0]      level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  ssr_frame_t          mem_q [DEPTH];
  logic [AW-1:0]       wr_q;
  logic [AW-1:0]       rd_q;
  logic [AW:0]         cnt_q;
  logic                push;
  logic                pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign level     = 2'(cnt_q);

  // Storage entries, written by index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : ssr_buf2

// File: design/ssr_top.sv
// How it works
// - While load select is high and no frame is pending, capture all switch states.
// - Load low freezes the capture; one bit leaves per link clock pulse.
// - Each transfer is 32 bits, one distinct function per bit.
// - A high request on a relay channel pulls its driver output low.
// - Seven room relays: television, radios, direct and indirect lights.
// - Motors use a supervisory relay plus six direction relays.
// - Supervisory relay is on whenever any motor request is active.
// - Motor power only when supervisory and direction relay are both on.
// - Requests from both siderails and pendant combine by OR.
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [31:0]         switch_in,
  input  wire logic                link_clk,
  input  wire logic                load_shift_select,
  output logic                     serial_data,
  input  wire logic [31:0]         other_rail_req,
  input  wire logic [5:0]          pendant_req,
  output ssr_room_t                room_relay_drv_n,
  output ssr_motor_t               motor_relay_drv_n,
  output logic                     supervisory_motor_relay_drv_n
);

  // Frame and channel widths follow the map header
  localparam int NB = `SSR_FRAME_BITS;
  localparam int NM = `SSR_MOTOR_N;
  localparam int NR = `SSR_ROOM_N;

  // Synchronised pin inputs
  logic [NB-1:0] sw_s;
  logic [NB-1:0] other_s;
  logic [NM-1:0] pend_s;
  logic          lclk_s;
  logic          load_s;

  // Scan and shift state
  logic          lclk_prev_q;
  logic          load_prev_q;
  logic [NB-1:0] shift_q;
  logic          serial_q;
  logic [5:0]    bits_q;
  ssr_frame_t    frame_q;
  logic          pend_q;

  // Buffer hand-shake
  logic          buf_in_ready;
  logic          buf_out_valid;
  logic          buf_out_ready;
  ssr_frame_t    buf_out_data;
  logic [1:0]    buf_level;

  // Decoder and relay state
  logic [NB-1:0] rx_word_q;
  logic [31:0]   frames_q;
  logic [NB-1:0] req_w;
  logic [NM-1:0] motor_on_q;
  logic [NR-1:0] room_on_q;
  logic          sup_on_q;
  logic [NM-1:0] motor_drv_n_q;
  logic [NR-1:0] room_drv_n_q;
  logic          sup_drv_n_q;
  logic [NM-1:0] motor_pwr_q;

  // Register bus state
  logic [31:0]   ctrl_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [31:0]   rd_mux;
  logic          addr_ok;

  // Edge strobes and bus helpers
  logic          lclk_fall;
  logic          load_fall;
  logic          wr_take;
  logic [2:0]    src_en;

  // Pins from the main board and the switches arrive asynchronously
  ssr_sync #(.W(NB)) u_sync_sw (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (switch_in),
    .sync_out (sw_s)
  );

  ssr_sync #(.W(NB)) u_sync_other (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (other_rail_req),
    .sync_out (other_s)
  );

  ssr_sync #(.W(NM + 2)) u_sync_ctl (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pendant_req, link_clk, load_shift_select}),
    .sync_out ({pend_s, lclk_s, load_s})
  );

  // Edge history of the synchronised link signals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      lclk_prev_q <= lclk_s;
      load_prev_q <= load_s;
    end
  end

  // A fall needs a high history, so leaving reset never fakes an edge
  assign lclk_fall = lclk_prev_q && !lclk_s;
  assign load_fall = load_prev_q && !load_s;

  // Shift register: capture, freeze and shift toward the data pin.
  // Capture pauses while a frozen frame waits for buffer room; a load
  // fall in that time is not handed to the decoder.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q  <= '0;
      serial_q <= 1'b0;
      bits_q   <= '0;
    end else if (load_s) begin
      if (!pend_q) begin
        shift_q  <= sw_s;
        serial_q <= sw_s[0];
      end
      bits_q <= '0;
    end else if (load_fall) begin
      serial_q <= shift_q[0];
      bits_q   <= 6'h01;
    end else if (lclk_fall) begin
      shift_q  <= {1'b0, shift_q[NB-1:1]};
      serial_q <= shift_q[1];
      if (bits_q != 6'(NB)) begin
        bits_q <= bits_q + 6'h01;
      end
    end
  end

  assign serial_data = serial_q;

  // Frozen frame waits here until the buffer accepts it
  // A load fall while a frame is still pending is dropped, not queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= '0;
      pend_q  <= 1'b0;
    end else if (load_fall && !pend_q) begin
      frame_q <= ssr_frame_t'(shift_q);
      pend_q  <= 1'b1;
    end else if (pend_q && buf_in_ready) begin
      pend_q <= 1'b0;
    end
  end

  // Software hold stalls the drain so the buffer really fills
  assign buf_out_ready = !ctrl_q[`SSR_CTRL_HOLD];

  ssr_buf2 #(.DEPTH(2)) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (pend_q),
    .in_ready  (buf_in_ready),
    .in_data   (frame_q),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data),
    .level     (buf_level)
  );

  // Latest decoded frame and frame count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word_q <= '0;
      frames_q  <= '0;
    end else if (buf_out_valid && buf_out_ready) begin
      rx_word_q <= buf_out_data.word;
      frames_q  <= frames_q + 32'h0000_0001;
    end
  end

  assign src_en = ctrl_q[`SSR_CTRL_SRC_LO +: `SSR_CTRL_SRC_W];
  always_comb begin
    req_w = '0;
    if (src_en[0]) req_w = req_w | rx_word_q;
    if (src_en[1]) req_w = req_w | other_s;
    if (src_en[2]) req_w[`SSR_MOTOR_LO +: NM] = req_w[`SSR_MOTOR_LO +: NM] | pend_s;
  end

  // Per-channel relay requests; global enable gates every coil
  // Limitation: opposing directions are not cancelled in this block
  genvar gm;
  generate
    for (gm = 0; gm < NM; gm++) begin : g_motor
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          motor_on_q[gm] <= 1'b0;
        end else begin
          motor_on_q[gm] <= req_w[`SSR_MOTOR_LO + gm] && ctrl_q[`SSR_CTRL_RELAY_EN];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          motor_drv_n_q[gm] <= 1'b1;
        end else begin
          motor_drv_n_q[gm] <= !motor_on_q[gm];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          motor_pwr_q[gm] <= 1'b0;
        end else begin
          motor_pwr_q[gm] <= sup_on_q && motor_on_q[gm];
        end
      end
    end
  endgenerate

  // Room channels use the same two-stage drive as the motors
  genvar gr;
  generate
    for (gr = 0; gr < NR; gr++) begin : g_room
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          room_on_q[gr] <= 1'b0;
        end else begin
          room_on_q[gr] <= req_w[`SSR_ROOM_LO + gr] && ctrl_q[`SSR_CTRL_RELAY_EN];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          room_drv_n_q[gr] <= 1'b1;
        end else begin
          room_drv_n_q[gr] <= !room_on_q[gr];
        end
      end
    end
  endgenerate

  // Supervisory relay follows the motor requests, not the direction chosen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_on_q    <= 1'b0;
      sup_drv_n_q <= 1'b1;
    end else begin
      sup_on_q    <= |(req_w[`SSR_MOTOR_LO +: NM]) && ctrl_q[`SSR_CTRL_RELAY_EN];
      sup_drv_n_q <= !sup_on_q;
    end
  end

  // Relay drivers leave the block straight from their flip-flops
  assign motor_relay_drv_n             = ssr_motor_t'(motor_drv_n_q);
  assign room_relay_drv_n              = ssr_room_t'(room_drv_n_q);
  assign supervisory_motor_relay_drv_n = sup_drv_n_q;

  // Register read decode, sampled in the setup cycle
  always_comb begin
    rd_mux  = '0;
    addr_ok = 1'b1;
    unique case (paddr)
      `SSR_OFS_CTRL:    rd_mux = ctrl_q;
      `SSR_OFS_STATUS: begin
        rd_mux[`SSR_ST_LEVEL_LO +: 2] = buf_level;
        rd_mux[`SSR_ST_PEND]          = pend_q;
        rd_mux[`SSR_ST_LOAD]          = load_s;
        rd_mux[`SSR_ST_BITS_LO +: 6]  = bits_q;
      end
      `SSR_OFS_RX_WORD: rd_mux = rx_word_q;
      `SSR_OFS_REQ:     rd_mux = req_w;
      `SSR_OFS_RELAY: begin
        rd_mux[`SSR_MOTOR_LO +: NM] = motor_on_q;
        rd_mux[`SSR_ROOM_LO +: NR]  = room_on_q;
        rd_mux[16 +: NM]            = motor_pwr_q;
        rd_mux[24]                  = sup_on_q;
      end
      `SSR_OFS_FRAMES:  rd_mux = frames_q;
      default:          addr_ok = 1'b0;
    endcase
  end

  // No wait state: answer is prepared in setup, given in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (psel && !penable) begin
      pready_q  <= 1'b1;
      pslverr_q <= !addr_ok;
      // Writes answer with zero data
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Bus answer outputs come straight from registers
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Control register write at the completing access edge
  assign wr_take = psel && penable && pready_q && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SSR_CTRL_RESET;
    end else if (wr_take && paddr == `SSR_OFS_CTRL) begin
      // Bits above the control fields read back as zero
      ctrl_q <= pwdata & 32'h0000_001f;
    end
  end

endmodule : ssr_top

// File: dv/ssr_top_asserts.sv
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_top_asserts
  import ssr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_data,
  input wire logic        link_clk,
  input wire logic        load_shift_select,
  input wire logic [5:0]  pendant_req,
  input wire ssr_motor_t  motor_relay_drv_n,
  input wire logic        supervisory_motor_relay_drv_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Every setup gets its access cycle with ready
  a_ready_next: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  // Ready stands one cycle only
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  // Error answer exactly for offsets outside the map
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {`SSR_OFS_CTRL, `SSR_OFS_STATUS,
                                `SSR_OFS_RX_WORD, `SSR_OFS_REQ, `SSR_OFS_RELAY, `SSR_OFS_FRAMES}))
    else $error("error flag wrong for address");
  // Error flag never stands alone
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Refused reads return zero, never stale data
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read with data");
  a_bit_steady: assert property ((!load_shift_select && link_clk) [*4] |=> $stable(serial_data))
    else $error("serial bit moved while link high");
  a_sup_any: assert property (motor_relay_drv_n != 6'h3f |-> !supervisory_motor_relay_drv_n)
    else $error("direction on without supervisory");
  a_sup_alone: assert property (!supervisory_motor_relay_drv_n |-> motor_relay_drv_n != 6'h3f)
    else $error("supervisory on without direction");
  a_pend_drive: assert property ($rose(pendant_req[0]) ##1 pendant_req[0] [*7] |-> !motor_relay_drv_n[0])
    else $error("pendant request not driven");

  c_frame: cover property ($fell(load_shift_select));
  c_err: cover property (pslverr);
  c_sup: cover property ($fell(supervisory_motor_relay_drv_n));
endmodule : ssr_top_asserts

// File: dv/ssr_main_model.sv
`timescale 1ns/1ps
module ssr_main_model (
  input  wire logic   start,
  input  wire logic   slow,
  input  wire logic   serial_data,
  output logic        link_clk,
  output logic        load_shift_select,
  output logic        busy,
  output logic [31:0] rx_word
);
  int half;

  initial begin
    link_clk = 1'b0;
    load_shift_select = 1'b1;
    busy = 1'b0;
    rx_word = 32'h0;
  end

  // clock and load from here
  // Link stands low between frames; the 37 ns offset keeps it off the pclk grid
  always @(posedge start) begin
    busy = 1'b1;
    half = slow ? 800 : 400;
    #837 load_shift_select = 1'b0;
    for (int k = 0; k < 32; k++) begin
      #(half) link_clk = 1'b1;
      rx_word[k] = serial_data;
      #(half) link_clk = 1'b0;
    end
    #(half) load_shift_select = 1'b1;
    busy = 1'b0;
  end
endmodule : ssr_main_model

// File: dv/siderail_serial_scan_and_relays_tb.sv
`timescale 1ns/1ps
`include "ssr_map.svh"
module siderail_serial_scan_and_relays_tb;
  import ssr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] switch_in = 32'h0;
  logic [31:0] other_rail_req = 32'h0;
  logic [5:0]  pendant_req = 6'h00;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rx_word;
  logic        pready;
  logic        pslverr;
  logic        serial_data;
  logic        link_clk;
  logic        load_shift_select;
  logic        busy;
  ssr_room_t   room_n;
  ssr_motor_t  motor_n;
  logic        sup_n;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #50 pclk = ~pclk;

  ssr_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_in(switch_in), .link_clk(link_clk), .load_shift_select(load_shift_select),
    .serial_data(serial_data), .other_rail_req(other_rail_req), .pendant_req(pendant_req),
    .room_relay_drv_n(room_n), .motor_relay_drv_n(motor_n), .supervisory_motor_relay_drv_n(sup_n));

  ssr_main_model u_main (.start(start), .slow(slow), .serial_data(serial_data), .link_clk(link_clk),
    .load_shift_select(load_shift_select), .busy(busy), .rx_word(rx_word));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // One APB transfer, held until ready is sampled; idle cycle after it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only ready or the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check(what, rd & m, exp);
  endtask : rd_chk

  // Low drive means coil on; any source sets a function
  function automatic logic [31:0] relay_exp(input logic [31:0] w, input logic [5:0] p);
    logic [5:0] m;
    m = w[`SSR_MOTOR_LO +: `SSR_MOTOR_N] | p;
    return {18'h0, ~(|m), ~w[`SSR_ROOM_LO +: `SSR_ROOM_N], ~m};
  endfunction : relay_exp

  // Relay register: motor on, room on, motor power (supervisory and direction), supervisory
  function automatic logic [31:0] relay_reg_exp(input logic [31:0] w, input logic [5:0] p);
    logic [5:0] m;
    m = w[`SSR_MOTOR_LO +: `SSR_MOTOR_N] | p;
    return {7'h0, |m, 2'h0, m & {6{|m}}, 1'h0, w[`SSR_ROOM_LO +: `SSR_ROOM_N], 2'h0, m};
  endfunction : relay_reg_exp

  task automatic frame(input logic [31:0] sw);
    int n;
    n = 0;
    switch_in <= sw;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    while (busy === 1'b1 && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    check("rx word", rx_word, sw);
  endtask : frame

  // A hang costs a mismatch; a frame takes a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] w, oth, rd, f0;
    logic [5:0]  p;
    logic        er;
    void'($urandom(32'h274ee26d));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`SSR_OFS_CTRL, 32'hffffffff, `SSR_CTRL_RESET, "ctrl reset");
    apb(1'b0, 8'h20, 32'h0, rd, er);
    check("unmapped err", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // Corner frames first (all off, all on at slow link, random word with pendant bit 0), then mixed sources
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
      oth = (i < 3) ? 32'h0 : $urandom;
      p = (i < 2) ? 6'h00 : (i == 2) ? 6'h01 : 6'($urandom);
      slow <= (i == 1);
      other_rail_req <= oth;
      pendant_req <= p;
      frame(w);
      repeat (20) @(posedge pclk);
      check("relays", {18'h0, sup_n, room_n, motor_n}, relay_exp(w | oth, p));
      rd_chk(`SSR_OFS_RELAY, 32'hffffffff, relay_reg_exp(w | oth, p), "relay reg");
    end
    // Drain held: the buffer fills, third frame waits pending
    apb(1'b1, `SSR_OFS_CTRL, `SSR_CTRL_RESET | 32'h1, rd, er);
    rd_chk(`SSR_OFS_CTRL, 32'hffffffff, 32'h1f, "ctrl rw");
    apb(1'b0, `SSR_OFS_FRAMES, 32'h0, f0, er);
    repeat (3) begin
      w = $urandom;
      frame(w);
    end
    rd_chk(`SSR_OFS_STATUS, 32'h7, 32'h6, "level full");
    apb(1'b1, `SSR_OFS_CTRL, `SSR_CTRL_RESET, rd, er);
    repeat (10) @(posedge pclk);
    rd_chk(`SSR_OFS_STATUS, 32'h7, 32'h0, "level empty");
    rd_chk(`SSR_OFS_FRAMES, 32'hffffffff, f0 + 32'd3, "frames");
    rd_chk(`SSR_OFS_RX_WORD, 32'hffffffff, w, "last word");
    check("relays", {18'h0, sup_n, room_n, motor_n}, relay_exp(w | oth, p));
    // Other rail as the only source, then all coils disabled
    apb(1'b1, `SSR_OFS_CTRL, 32'h0000_000a, rd, er);
    repeat (5) @(posedge pclk);
    rd_chk(`SSR_OFS_REQ, 32'hffffffff, oth, "req other only");
    check("relays other", {18'h0, sup_n, room_n, motor_n}, relay_exp(oth, 6'h00));
    apb(1'b1, `SSR_OFS_CTRL, 32'h0000_001c, rd, er);
    repeat (5) @(posedge pclk);
    check("relays off", {18'h0, sup_n, room_n, motor_n}, 32'h0000_3fff);
    report_and_stop();
  end
endmodule : siderail_serial_scan_and_relays_tb

bind ssr_top ssr_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_data(serial_data),
  .link_clk(link_clk), .load_shift_select(load_shift_select), .pendant_req(pendant_req),
  .motor_relay_drv_n(motor_relay_drv_n), .supervisory_motor_relay_drv_n(supervisory_motor_relay_drv_n));
